// ===== rtl/icd_map.svh
// Offsets, field positions and opcode constants for the instruction-class decode core.
// Assumes inclusion by bare name from the core file.
`ifndef ICD_MAP_SVH
`define ICD_MAP_SVH
`define ICD_BTB_HI 4'h0
`define ICD_BITRW_HI 4'h1
`define ICD_REL_HI 4'h2
`define ICD_DIR_HI 4'h3
`define ICD_INHA_HI 4'h4
`define ICD_INHX_HI 4'h5
`define ICD_IX1_HI 4'h6
`define ICD_IX_HI 4'h7
`define ICD_CTL_HI 4'h9
`define ICD_PWR_HI 4'h8
`define ICD_RM_DIR 4'hB
`define ICD_RM_EXT 4'hC
`define ICD_OP_ALWAYS 4'h0
`define ICD_OP_NEVER 4'h1
`define ICD_OP_PINLOW 4'hE
`define ICD_OP_PINHIGH 4'hF
`define ICD_OP_JUMP 4'hC
`define ICD_OP_JUMPSUB 4'hD
`define ICD_OP_TEST 4'hD
`define ICD_OP_CLR 4'hF
`define ICD_OP_COM 4'h3
`define ICD_OP_INC 4'hC
`define ICD_OP_DEC 4'hA
`define ICD_OP_NEG 4'h0
`define ICD_OP_LDA 4'h6
`define ICD_OP_STA 4'h7
`define ICD_OP_LDX 4'hE
`define ICD_OP_STX 4'hF
`define ICD_OP_ADD 4'hB
`define ICD_OP_SUB 4'h0
`define ICD_OP_AND 4'h4
`define ICD_OP_ORA 4'hA
`define ICD_OP_EOR 4'h8
`define ICD_OP_ATOX 4'h7
`define ICD_OP_XTOA 4'hF
`define ICD_OP_CLC 4'h8
`define ICD_OP_SEC 4'h9
`define ICD_OP_CLI 4'hA
`define ICD_OP_SEI 4'hB
`define ICD_OP_STOP 4'hE
`define ICD_OP_WAIT 4'hF
`define ICD_RESET_PC 16'h0100
`define ICD_DIR_PAGE 8'h00
`endif

// ===== rtl/icd_pkg.sv
// Types of the instruction-class decode core; its pin synchroniser keeps its own.
// Assumes icd_map.svh is reachable by bare name.
package icd_pkg;
	typedef enum logic [3:0] {
		ST_FETCH = 4'h0,
		ST_OPND1 = 4'h1,
		ST_OPND2 = 4'h2,
		ST_READ = 4'h3,
		ST_WRITE = 4'h4,
		ST_EXEC = 4'h5,
		ST_STOP = 4'h6,
		ST_WAIT = 4'h7
	} icd_state_type;
endpackage

// ===== rtl/icd_pin_sync.sv
// Three-stage synchroniser for an asynchronous pin input.
// Assumes the pin is unrelated to sys_clk; output changes once stages two and three agree.
`timescale 1ns/10ps
module icd_pin_sync (
	input wire logic sys_clk, // Core clock.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire logic clkEn, // Freezes the stages while low.
	input wire logic pinIn, // Raw pin level.
	output logic pinSync // Filtered level.
);
	typedef struct packed {
		logic [2:0] stage;
		logic level;
	} icd_sync_type;
	icd_sync_type sync_q;
	icd_sync_type sync_d;

	always_comb begin
		sync_d = sync_q;
		sync_d.stage = {sync_q.stage[1:0], pinIn};
		if (sync_q.stage[1] == sync_q.stage[2]) begin
			sync_d.level = sync_q.stage[2];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			// The pin idles high, so reset to that level to avoid a false low after reset.
			sync_q <= '1;
		end else if (clkEn) begin
			sync_q <= sync_d;
		end
	end

	assign pinSync = sync_q.level;
endmodule

// ===== rtl/icd_core.sv
// Instruction-class decode and execute core of a small 8-bit CPU.
// Assumes read data stand in the same cycle as memRd and are taken at its closing edge.
`timescale 1ns/10ps
`include "icd_map.svh"

// Contract
// - Register/memory: acc or index with memory
// - Read-modify-write writes result back same place
// - Test negative-zero skips the write-back
// - Jumps load PC from effective address
// - False branch condition falls through
// - Branch target is PC plus signed offset
// - Bit-branch: three bytes, direct plus relative
// - Second byte address, third byte offset
// - Opcode gives bit number and polarity
// - Bit-branch range -128 to +127
// - Tested bit copied into carry always
// - Bit set/clear changes only one bit
// - Bit instructions use direct addressing only
// - Control instructions inherent, no memory operand
// - Halt oscillator and enable external interrupt
// - Wait halts clock, enables interrupts
// - Branches on interrupt pin high/low
// - Copy acc to index and back
// - Direct address high byte forced zero
module icd_core (
	input wire logic sys_clk, // Core clock, 100 MHz.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire logic clkEn, // Freezes all state while low.
	input wire logic irqPin, // External interrupt pin level.
	input wire logic irqReq, // Pending interrupt request, same clock.
	input wire logic [7:0] memRdata, // Read data, in the same cycle as memRd.
	output logic [15:0] memAddr, // Bus address.
	output logic memRd, // Read strobe.
	output logic memWr, // Write strobe.
	output logic [7:0] memWdata, // Write data.
	output logic [7:0] accOut, // Accumulator.
	output logic [7:0] idxOut, // Index register.
	output logic [15:0] pcOut, // Program counter.
	output logic [4:0] ccrOut, // Flags H I N Z C.
	output logic oscStop, // Oscillator halted.
	output logic cpuWait, // CPU clock halted.
	output logic [2:0] insnClass // Class of the current opcode.
);
	import icd_pkg::*;

	typedef struct packed {
		icd_state_type state;
		logic [15:0] pc;
		logic [7:0] acc;
		logic [7:0] idx;
		logic [4:0] ccr;
		logic [7:0] opcode;
		logic [7:0] op1;
		logic [7:0] data;
		logic [15:0] ea;
		logic [15:0] addr;
		logic rd;
		logic wr;
		logic [7:0] wdata;
		logic [2:0] cls;
		logic stopped;
		logic waiting;
	} icd_core_type;

	icd_core_type core_q;
	icd_core_type core_d;
	logic irqLevel;
	logic [3:0] hi;
	logic [3:0] lo;
	logic [2:0] bitSel;
	logic polarity;
	logic relCond;
	logic [7:0] rmwRes;
	logic [15:0] relTarget;
	logic [7:0] rmwIn;

	icd_pin_sync u_irq_sync (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clkEn(clkEn),
		.pinIn(irqPin),
		.pinSync(irqLevel)
	);

	assign hi = core_q.opcode[7:4];
	assign lo = core_q.opcode[3:0];
	assign bitSel = core_q.opcode[3:1];
	assign polarity = core_q.opcode[0];

	// ----------------------------------------------------------------
	// Branch condition and target
	// ----------------------------------------------------------------
	always_comb begin
		case (lo)
			`ICD_OP_ALWAYS: relCond = 1'b1;
			`ICD_OP_NEVER: relCond = 1'b0;
			4'h4: relCond = ~core_q.ccr[0];
			4'h5: relCond = core_q.ccr[0];
			4'h6: relCond = ~core_q.ccr[1];
			4'h7: relCond = core_q.ccr[1];
			4'h8: relCond = ~core_q.ccr[4];
			4'h9: relCond = core_q.ccr[4];
			4'hA: relCond = ~core_q.ccr[2];
			4'hB: relCond = core_q.ccr[2];
			4'hC: relCond = ~core_q.ccr[3];
			4'hD: relCond = core_q.ccr[3];
			`ICD_OP_PINLOW: relCond = ~irqLevel;
			`ICD_OP_PINHIGH: relCond = irqLevel;
			default: relCond = 1'b0;
		endcase
	end

	// Sign-extended offset from the already advanced PC spans -128 to +127.
	assign relTarget = core_q.pc + {{8{core_q.data[7]}}, core_q.data};

	// ----------------------------------------------------------------
	// Read-modify-write operation
	// ----------------------------------------------------------------
	// Inherent forms take the accumulator or index as operand instead of memory.
	assign rmwIn = (hi == `ICD_INHA_HI) ? core_q.acc : ((hi == `ICD_INHX_HI) ? core_q.idx : core_q.data);

	always_comb begin
		case (lo)
			`ICD_OP_NEG: rmwRes = 8'h00 - rmwIn;
			`ICD_OP_COM: rmwRes = ~rmwIn;
			4'h4: rmwRes = {1'b0, rmwIn[7:1]};
			4'h6: rmwRes = {core_q.ccr[0], rmwIn[7:1]};
			4'h7: rmwRes = {rmwIn[7], rmwIn[7:1]};
			4'h8: rmwRes = {rmwIn[6:0], 1'b0};
			4'h9: rmwRes = {rmwIn[6:0], core_q.ccr[0]};
			`ICD_OP_DEC: rmwRes = rmwIn - 8'h01;
			`ICD_OP_INC: rmwRes = rmwIn + 8'h01;
			`ICD_OP_CLR: rmwRes = 8'h00;
			default: rmwRes = rmwIn;
		endcase
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	// Read data are taken at the edge that closes the cycle in which memRd stands.
	// Every state that samples memRdata is entered with the strobe raised, except ST_READ for STA and STX.
	always_comb begin
		logic [7:0] alu;
		logic [7:0] bitMask;
		alu = 8'h00;
		bitMask = 8'h01 << bitSel;
		core_d = core_q;
		core_d.rd = 1'b0;
		core_d.wr = 1'b0;
		case (core_q.state)
			ST_FETCH: begin
				if (core_q.rd) begin
					core_d.opcode = memRdata;
					case (memRdata[7:4])
						`ICD_BTB_HI, `ICD_BITRW_HI: core_d.cls = 3'h3;
						`ICD_REL_HI, `ICD_RM_EXT: core_d.cls = 3'h2;
						`ICD_DIR_HI, `ICD_INHA_HI, `ICD_INHX_HI, `ICD_IX1_HI, `ICD_IX_HI: core_d.cls = 3'h1;
						`ICD_CTL_HI, `ICD_PWR_HI: core_d.cls = 3'h4;
						default: core_d.cls = 3'h0;
					endcase
					if (memRdata[7:4] == `ICD_CTL_HI || memRdata[7:4] == `ICD_INHA_HI
						|| memRdata[7:4] == `ICD_INHX_HI || memRdata[7:4] == `ICD_PWR_HI) begin
						core_d.state = ST_EXEC;
					end else begin
						core_d.state = ST_OPND1;
						core_d.addr = core_q.pc;
						core_d.pc = core_q.pc + 16'h0001;
						core_d.rd = 1'b1;
					end
				end else begin
					core_d.addr = core_q.pc;
					core_d.pc = core_q.pc + 16'h0001;
					core_d.rd = 1'b1;
				end
			end
			ST_OPND1: begin
				core_d.op1 = memRdata;
				core_d.data = memRdata;
				core_d.ea = {`ICD_DIR_PAGE, memRdata};
				if (hi == `ICD_RM_EXT || hi == `ICD_BTB_HI) begin
					core_d.state = ST_OPND2;
					core_d.addr = core_q.pc;
					core_d.pc = core_q.pc + 16'h0001;
					core_d.rd = 1'b1;
				end else if (hi == `ICD_REL_HI) begin
					core_d.state = ST_EXEC;
				end else if (hi == `ICD_IX1_HI || hi == `ICD_IX_HI) begin
					core_d.ea = 16'({`ICD_DIR_PAGE, memRdata}) + {8'h00, core_q.idx};
					core_d.addr = 16'({`ICD_DIR_PAGE, memRdata}) + {8'h00, core_q.idx};
					core_d.state = ST_READ;
					core_d.rd = 1'b1;
				end else if (hi == `ICD_RM_DIR && lo == `ICD_OP_JUMP) begin
					core_d.state = ST_EXEC;
				end else begin
					core_d.addr = {`ICD_DIR_PAGE, memRdata};
					core_d.state = ST_READ;
					// Only stores skip the read; bit and modify forms share these low codes.
					core_d.rd = (hi != `ICD_RM_DIR) || ((lo != `ICD_OP_STA) && (lo != `ICD_OP_STX));
				end
			end
			ST_OPND2: begin
				if (hi == `ICD_BTB_HI) begin
					core_d.data = memRdata;
					core_d.addr = core_q.ea;
					core_d.state = ST_READ;
					core_d.rd = 1'b1;
				end else begin
					core_d.ea = {core_q.op1, memRdata};
					core_d.addr = {core_q.op1, memRdata};
					core_d.state = (lo == `ICD_OP_JUMP || lo == `ICD_OP_JUMPSUB) ? ST_EXEC : ST_READ;
					core_d.rd = (lo != `ICD_OP_JUMP) && (lo != `ICD_OP_JUMPSUB) && (lo != `ICD_OP_STA)
						&& (lo != `ICD_OP_STX);
				end
			end
			ST_READ: begin
				if (hi == `ICD_BTB_HI) begin
					core_d.ccr[0] = memRdata[bitSel];
					if (memRdata[bitSel] == ~polarity) begin
						core_d.pc = relTarget;
					end
					core_d.state = ST_FETCH;
				end else if (hi == `ICD_BITRW_HI) begin
					core_d.wdata = polarity ? (memRdata & ~bitMask) : (memRdata | bitMask);
					core_d.wr = 1'b1;
					core_d.state = ST_WRITE;
				end else begin
					core_d.data = memRdata;
					core_d.state = ST_EXEC;
				end
			end
			ST_EXEC: begin
				core_d.state = ST_FETCH;
				if (hi == `ICD_REL_HI) begin
					if (relCond) begin
						core_d.pc = relTarget;
					end
				end else if (hi == `ICD_RM_DIR || hi == `ICD_RM_EXT) begin
					case (lo)
						`ICD_OP_JUMP, `ICD_OP_JUMPSUB: core_d.pc = core_q.ea;
						`ICD_OP_LDA: core_d.acc = core_q.data;
						`ICD_OP_LDX: core_d.idx = core_q.data;
						`ICD_OP_ADD: core_d.acc = core_q.acc + core_q.data;
						`ICD_OP_SUB: core_d.acc = core_q.acc - core_q.data;
						`ICD_OP_AND: core_d.acc = core_q.acc & core_q.data;
						`ICD_OP_ORA: core_d.acc = core_q.acc | core_q.data;
						`ICD_OP_EOR: core_d.acc = core_q.acc ^ core_q.data;
						`ICD_OP_STA, `ICD_OP_STX: begin
							core_d.wdata = (lo == `ICD_OP_STA) ? core_q.acc : core_q.idx;
							core_d.addr = core_q.ea;
							core_d.wr = 1'b1;
							core_d.state = ST_WRITE;
						end
						default: core_d.acc = core_q.acc;
					endcase
					alu = core_d.acc;
					core_d.ccr[2] = alu[7];
					core_d.ccr[1] = (alu == 8'h00);
				end else if (hi == `ICD_CTL_HI) begin
					case (lo)
						`ICD_OP_ATOX: core_d.idx = core_q.acc;
						`ICD_OP_XTOA: core_d.acc = core_q.idx;
						`ICD_OP_CLC: core_d.ccr[0] = 1'b0;
						`ICD_OP_SEC: core_d.ccr[0] = 1'b1;
						`ICD_OP_CLI: core_d.ccr[3] = 1'b0;
						`ICD_OP_SEI: core_d.ccr[3] = 1'b1;
						default: core_d.ccr = core_q.ccr;
					endcase
				end else if (hi == `ICD_PWR_HI) begin
					// Power codes live in their own row so they never alias the transfers.
					case (lo)
						`ICD_OP_STOP: begin
							core_d.ccr[3] = 1'b0;
							core_d.state = ST_STOP;
						end
						`ICD_OP_WAIT: begin
							core_d.ccr[3] = 1'b0;
							core_d.state = ST_WAIT;
						end
						default: core_d.state = ST_FETCH;
					endcase
				end else begin
					// Register forms write back into the register and never touch the bus.
					core_d.data = rmwIn;
					core_d.ccr[2] = rmwRes[7];
					core_d.ccr[1] = (rmwRes == 8'h00);
					if (lo != `ICD_OP_TEST) begin
						if (hi == `ICD_INHA_HI) begin
							core_d.acc = rmwRes;
						end else if (hi == `ICD_INHX_HI) begin
							core_d.idx = rmwRes;
						end else begin
							core_d.wdata = rmwRes;
							core_d.addr = core_q.ea;
							core_d.wr = 1'b1;
							core_d.state = ST_WRITE;
						end
					end
				end
			end
			ST_WRITE: begin
				core_d.state = ST_FETCH;
			end
			ST_STOP, ST_WAIT: begin
				if (irqReq || ((core_q.state == ST_STOP) && !irqLevel)) begin
					core_d.state = ST_FETCH;
				end
			end
			default: core_d.state = ST_FETCH;
		endcase
		// Power flags follow the next state so the outputs come straight from flops.
		core_d.stopped = (core_d.state == ST_STOP);
		core_d.waiting = (core_d.state == ST_WAIT);
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			core_q <= '0;
			core_q.pc <= `ICD_RESET_PC;
			core_q.state <= ST_FETCH;
		end else if (clkEn) begin
			core_q <= core_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign memAddr = core_q.addr;
	assign memRd = core_q.rd;
	assign memWr = core_q.wr;
	assign memWdata = core_q.wdata;
	assign accOut = core_q.acc;
	assign idxOut = core_q.idx;
	assign pcOut = core_q.pc;
	assign ccrOut = core_q.ccr;
	assign oscStop = core_q.stopped;
	assign cpuWait = core_q.waiting;
	assign insnClass = core_q.cls;
endmodule

// ===== dv/icd_mem_model.sv
// Memory and peripheral bus partner for the decode core.
// Assumes one read strobe per byte; data stand while the strobe does and are taken at its closing edge.
`timescale 1ns/10ps
module icd_mem_model (
	input wire logic sys_clk, // Core clock.
	input wire logic [15:0] memAddr, // Bus address.
	input wire logic memRd, // Read strobe.
	input wire logic memWr, // Write strobe.
	input wire logic [7:0] memWdata, // Write data.
	output logic [7:0] memRdata // Read data.
);
	logic [7:0] store [0:65535];
	logic idleBit = 1'b0;
	initial begin
		foreach (store[i]) store[i] = 8'h97;
	end
	// Outside the data cycle the bus toggles so stale data never looks valid.
	always @(posedge sys_clk) begin
		if (memWr) store[memAddr] <= memWdata;
		idleBit <= ~idleBit;
	end
	assign memRdata = memRd ? store[memAddr] : {8{idleBit}};
endmodule

// ===== dv/icd_core_checker.sv
// Bus and power-state assertions for the decode core.
// Assumes binding to the core with every port connected by name.
`timescale 1ns/10ps
module icd_core_checker (
	input wire logic sys_clk, // Core clock.
	input wire logic rst_n, // Reset, active low.
	input wire logic clkEn, // Run enable.
	input wire logic irqPin, // Interrupt pin.
	input wire logic irqReq, // Interrupt request.
	input wire logic [7:0] memRdata, // Read data.
	input wire logic [15:0] memAddr, // Bus address.
	input wire logic memRd, // Read strobe.
	input wire logic memWr, // Write strobe.
	input wire logic [7:0] memWdata, // Write data.
	input wire logic [7:0] accOut, // Accumulator.
	input wire logic [7:0] idxOut, // Index register.
	input wire logic [15:0] pcOut, // Program counter.
	input wire logic [4:0] ccrOut, // Flags.
	input wire logic oscStop, // Stopped.
	input wire logic cpuWait, // Waiting.
	input wire logic [2:0] insnClass // Class.
);
	logic [15:0] rdAddr_q;
	logic [7:0] rdData_q;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdAddr_q <= 16'h0000;
			rdData_q <= 8'h00;
		end else begin
			if (memRd) rdAddr_q <= memAddr;
			if (memRd) rdData_q <= memRdata;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence bitWrite;
		memWr && insnClass == 3'h3;
	endsequence
	sequence waitWake;
		cpuWait && irqReq;
	endsequence
	rw_excl_a: assert property (!(memRd && memWr))
		else $error("read and write strobes together");
	rmw_same_a: assert property (memWr && (insnClass == 3'h1 || insnClass == 3'h3) |-> memAddr == rdAddr_q)
		else $error("write-back address differs from read");
	bit_one_a: assert property (bitWrite |-> $countones(memWdata ^ rdData_q) <= 1)
		else $error("bit write changes other than one bit");
	bit_direct_a: assert property (bitWrite |-> memAddr[15:8] == 8'h00)
		else $error("bit write outside direct page");
	wait_idle_a: assert property (cpuWait |-> !memRd && !memWr)
		else $error("bus active while waiting");
	stop_idle_a: assert property (oscStop |-> !memRd && !memWr)
		else $error("bus active while stopped");
	wait_unmask_a: assert property ($rose(cpuWait) |-> ##[0:2] !ccrOut[3])
		else $error("mask left set in wait");
	stop_unmask_a: assert property ($rose(oscStop) |-> ##[0:2] !ccrOut[3])
		else $error("mask left set in stop");
	wait_wake_a: assert property (waitWake |-> ##[1:4] !cpuWait)
		else $error("wait not left on request");
endmodule

// ===== dv/icd_core_tb.sv
// Self-checking bench for the decode core with a behavioural memory.
// Assumes the programs run from the reset address and the operand sits at 0x0040.
`timescale 1ns/10ps
module icd_core_tb;
	logic sys_clk = 1'b0, rst_n = 1'b0, irqPin = 1'b1, irqReq = 1'b0;
	logic memRd, memWr, oscStop, cpuWait;
	logic [7:0] memRdata, memWdata, accOut, idxOut, wrD;
	logic [15:0] memAddr, pcOut, wrA;
	logic [4:0] ccrOut;
	logic [2:0] insnClass;
	int err_count = 0, samples_checked = 0;
	always #5 sys_clk = ~sys_clk;
	icd_core dut(.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(1'b1), .irqPin(irqPin), .irqReq(irqReq),
		.memRdata(memRdata), .memAddr(memAddr), .memRd(memRd), .memWr(memWr), .memWdata(memWdata),
		.accOut(accOut), .idxOut(idxOut), .pcOut(pcOut), .ccrOut(ccrOut), .oscStop(oscStop),
		.cpuWait(cpuWait), .insnClass(insnClass));
	icd_mem_model mdl(.sys_clk(sys_clk), .memAddr(memAddr), .memRd(memRd), .memWr(memWr),
		.memWdata(memWdata), .memRdata(memRdata));
	always @(negedge sys_clk) if (memWr === 1'b1) begin
		wrA = memAddr;
		wrD = memWdata;
	end
	// ----------------------------------------
	// Shared tasks.
	// ----------------------------------------
	task automatic summarize;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic boot(input logic [31:0] p, input logic [7:0] v);
		rst_n = 1'b0;
		repeat (5) @(negedge sys_clk);
		{mdl.store[16'h0100], mdl.store[16'h0101], mdl.store[16'h0102], mdl.store[16'h0103]} = p;
		mdl.store[16'h0040] = v;
		wrA = 16'hFFFF;
		rst_n = 1'b1;
	endtask
	// Returns the address of the n-th read strobe.
	task automatic rd(input int n, output logic [15:0] a);
		int c = 0;
		int t = 0;
		a = 16'h0000;
		while (c < n && t < 200) begin
			@(negedge sys_clk);
			t++;
			if (memRd === 1'b1) begin
				c++;
				a = memAddr;
			end
		end
		if (c < n) begin
			err_count++;
			summarize();
		end
	endtask
	task automatic go(input logic [31:0] p, input logic [7:0] v, input int n, input logic [15:0] e);
		logic [15:0] a;
		boot(p, v);
		rd(n, a);
		chk(a, e);
	endtask
	task automatic waitpw(input bit stp, input logic v);
		int t = 0;
		while ((stp ? oscStop : cpuWait) !== v && t < 50) begin
			@(negedge sys_clk);
			t++;
		end
		if (t == 50) begin
			err_count++;
			summarize();
		end
	endtask
	// ----------------------------------------
	// Scenarios.
	// ----------------------------------------
	task automatic t_reset;
		rst_n = 1'b0;
		repeat (2) @(negedge sys_clk);
		chk(pcOut, 16'h0100);
		go(32'h9797_9797, 8'h00, 1, 16'h0100);
		$display("reset test done");
	endtask
	task automatic t_bitbr;
		logic [15:0] a, e;
		logic [7:0] off, v;
		for (int i = 0; i < 32; i++) begin
			off = i[0] ? 8'h80 : 8'h7F;
			v = 8'h01 << i[2:0];
			if (!i[4]) v = ~v;
			e = (i[4] ^ i[3]) ? 16'h0103 + {{8{off[7]}}, off} : 16'h0103;
			boot({4'h0, i[2:0], i[3], 8'h40, off, 8'h97}, v);
			rd(4, a);
			chk(a, 16'h0040);
			rd(1, a);
			chk(a, e);
			chk(16'(ccrOut[0]), 16'(i[4]));
		end
		$display("bit branch test done");
	endtask
	task automatic t_bitset;
		logic [7:0] m;
		for (int i = 0; i < 16; i++) begin
			m = 8'h01 << i[2:0];
			go({4'h1, i[2:0], i[3], 24'h4097_97}, 8'hA5, 4, 16'h0102);
			chk(wrA, 16'h0040);
			chk(16'(wrD), 16'(i[3] ? 8'hA5 & ~m : 8'hA5 | m));
		end
		$display("bit set test done");
	endtask
	task automatic t_rmw;
		go(32'h3C40_9797, 8'h7F, 4, 16'h0102);
		chk(wrA, 16'h0040);
		chk(16'(wrD), 16'h0080);
		go(32'h3D40_9797, 8'h80, 4, 16'h0102);
		chk(wrA, 16'hFFFF);
		$display("rmw test done");
	endtask
	task automatic t_jump;
		go(32'hCC12_3400, 8'h00, 4, 16'h1234);
		go(32'hBC40_0000, 8'h00, 3, 16'h0040);
		go(32'hCD12_3400, 8'h00, 4, 16'h1234);
		$display("jump test done");
	endtask
	task automatic t_rel;
		go(32'h2080_9797, 8'h00, 3, 16'h0082);
		go(32'h2110_9797, 8'h00, 3, 16'h0102);
		go(32'h9797_2F10, 8'h00, 5, 16'h0114);
		go(32'h9797_2E10, 8'h00, 5, 16'h0104);
		irqPin = 1'b0;
		go(32'h9797_2E10, 8'h00, 5, 16'h0114);
		go(32'h9797_2F10, 8'h00, 5, 16'h0104);
		irqPin = 1'b1;
		$display("relative test done");
	endtask
	task automatic t_xfer;
		go(32'hB640_9798, 8'h5A, 5, 16'h0103);
		chk(16'(idxOut), 16'h005A);
		go(32'hBE40_9F98, 8'hC3, 5, 16'h0103);
		chk(16'(accOut), 16'h00C3);
		$display("transfer test done");
	endtask
	task automatic t_power;
		boot(32'h9B8F_9797, 8'h00);
		waitpw(1'b0, 1'b1);
		chk(16'(ccrOut[3]), 16'h0000);
		irqReq = 1'b1;
		waitpw(1'b0, 1'b0);
		irqReq = 1'b0;
		boot(32'h9B8E_9797, 8'h00);
		waitpw(1'b1, 1'b1);
		chk(16'(ccrOut[3]), 16'h0000);
		irqPin = 1'b0;
		waitpw(1'b1, 1'b0);
		irqPin = 1'b1;
		$display("power test done");
	endtask
	initial begin
		t_reset;
		t_bitbr;
		t_bitset;
		t_rmw;
		t_jump;
		t_rel;
		t_xfer;
		t_power;
		summarize;
	end
endmodule
bind icd_core icd_core_checker chk_i(.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn), .irqPin(irqPin),
	.irqReq(irqReq), .memRdata(memRdata), .memAddr(memAddr), .memRd(memRd), .memWr(memWr),
	.memWdata(memWdata), .accOut(accOut), .idxOut(idxOut), .pcOut(pcOut), .ccrOut(ccrOut),
	.oscStop(oscStop), .cpuWait(cpuWait), .insnClass(insnClass));
